// ### src/jpr_target.v
// Purpose: Target-side debug port: TAP, debug control, reset split, returned clock
// Assumes: Test clock far slower than clk (at most 1/6 of it)
// Notes:   Test clock is sampled, not used as a clock
`timescale 1ns/10ps
`include "jpr_map.vh"

// How it works
// [RULE_01] Test reset and system reset are separate inputs; neither drives the other.
// [RULE_02] Test reset clears only the TAP controller and the debug control logic.
// [RULE_03] System reset clears only the core state; TAP and debug logic survive.
// [RULE_04] Probe asserts both resets, frees test reset, requests break, frees system reset.
// [RULE_05] Break pending at system reset release halts the core before its first instruction.
// [RULE_06] Probe restarts the whole start-up after any reset clearing TAP or debug logic; after test reset the bench only resets the TAP and reads the ID.
// [RULE_07] Probe reinitialises the link after a break such as a test clock glitch; the probe model only sets link_fail and goes on.
// [RULE_08] Test clock is synchronised to clk and returned on the returned clock output.
// [RULE_09] In adaptive mode probe waits for each returned edge before the next edge.
// [RULE_10] In fixed mode probe keeps test clock at most one sixth or eighth of core.
// [RULE_11] Optional outputs rest inactive: returned clock and acknowledge low.
// [RULE_12] In hand-over the probe releases outputs so clock holds and no reset occurs.
// [RULE_13] TDI and TMS sampled on rising test clock; TDO changes on falling edge.
// [RULE_14] Probe times out waiting for a returned edge and reports a link failure.
module jpr_target #(
	parameter [31:0] IDCODE_VAL = 32'h1234_5001 // Arbitrary value
) (
	// Clock and reset
	input  wire clk,
	input  wire arst_n,
	// Link pins from the probe
	input  wire tck,
	input  wire tms,
	input  wire tdi,
	input  wire test_reset_n,
	input  wire system_reset_n,
	input  wire debug_request,
	// Link pins to the probe
	output reg  tdo_ff,
	output reg  tdo_oe_ff,
	output reg  returned_test_clock_ff,
	output reg  debug_acknowledge_ff,
	// Towards the core
	output reg  core_reset_n_ff,
	output reg  debug_logic_reset_n_ff,
	output reg  core_run_ff
);

	// ==========================================================
	// TAP states
	localparam [15:0] ST_TLR  = 16'h0001;
	localparam [15:0] ST_RTI  = 16'h0002;
	localparam [15:0] ST_SDS  = 16'h0004;
	localparam [15:0] ST_CDR  = 16'h0008;
	localparam [15:0] ST_SHDR = 16'h0010;
	localparam [15:0] ST_E1D  = 16'h0020;
	localparam [15:0] ST_PDR  = 16'h0040;
	localparam [15:0] ST_E2D  = 16'h0080;
	localparam [15:0] ST_UDR  = 16'h0100;
	localparam [15:0] ST_SIS  = 16'h0200;
	localparam [15:0] ST_CIR  = 16'h0400;
	localparam [15:0] ST_SHIR = 16'h0800;
	localparam [15:0] ST_E1I  = 16'h1000;
	localparam [15:0] ST_PIR  = 16'h2000;
	localparam [15:0] ST_E2I  = 16'h4000;
	localparam [15:0] ST_UIR  = 16'h8000;

	// ==========================================================
	// Pin synchronisers
	wire tck_lvl;
	wire tck_rise;
	wire tck_fall;
	wire tms_lvl;
	wire tdi_lvl;
	wire trst_lvl;
	wire sys_rst_lvl;
	wire sys_rst_rise;
	wire dbg_req_lvl;

	// Same depth on every pin keeps TMS/TDI aligned to the clock edge
	jpr_pin_sync #(.INIT(`JPR_LOW)) u_tck (
		.clk(clk), .arst_n(arst_n), .pin(tck),
		.level_ff(tck_lvl), .rise_ff(tck_rise), .fall_ff(tck_fall)
	);
	jpr_pin_sync #(.INIT(`JPR_HIGH)) u_tms (
		.clk(clk), .arst_n(arst_n), .pin(tms),
		.level_ff(tms_lvl), .rise_ff(), .fall_ff()
	);
	jpr_pin_sync #(.INIT(`JPR_LOW)) u_tdi (
		.clk(clk), .arst_n(arst_n), .pin(tdi),
		.level_ff(tdi_lvl), .rise_ff(), .fall_ff()
	);
	jpr_pin_sync #(.INIT(`JPR_LOW)) u_trst (
		.clk(clk), .arst_n(arst_n), .pin(test_reset_n),
		.level_ff(trst_lvl), .rise_ff(), .fall_ff()
	);
	jpr_pin_sync #(.INIT(`JPR_LOW)) u_sys_rst (
		.clk(clk), .arst_n(arst_n), .pin(system_reset_n),
		.level_ff(sys_rst_lvl), .rise_ff(sys_rst_rise), .fall_ff()
	);
	jpr_pin_sync #(.INIT(`JPR_LOW)) u_dbg_req (
		.clk(clk), .arst_n(arst_n), .pin(debug_request),
		.level_ff(dbg_req_lvl), .rise_ff(), .fall_ff()
	);

	// ==========================================================
	// TAP next state
	reg [15:0] state_ff;
	reg [15:0] nxt_state;

	always @* begin
		case (state_ff)
			ST_TLR:  nxt_state = tms_lvl ? ST_TLR  : ST_RTI;
			ST_RTI:  nxt_state = tms_lvl ? ST_SDS  : ST_RTI;
			ST_SDS:  nxt_state = tms_lvl ? ST_SIS  : ST_CDR;
			ST_CDR:  nxt_state = tms_lvl ? ST_E1D  : ST_SHDR;
			ST_SHDR: nxt_state = tms_lvl ? ST_E1D  : ST_SHDR;
			ST_E1D:  nxt_state = tms_lvl ? ST_UDR  : ST_PDR;
			ST_PDR:  nxt_state = tms_lvl ? ST_E2D  : ST_PDR;
			ST_E2D:  nxt_state = tms_lvl ? ST_UDR  : ST_SHDR;
			ST_UDR:  nxt_state = tms_lvl ? ST_SDS  : ST_RTI;
			ST_SIS:  nxt_state = tms_lvl ? ST_TLR  : ST_CIR;
			ST_CIR:  nxt_state = tms_lvl ? ST_E1I  : ST_SHIR;
			ST_SHIR: nxt_state = tms_lvl ? ST_E1I  : ST_SHIR;
			ST_E1I:  nxt_state = tms_lvl ? ST_UIR  : ST_PIR;
			ST_PIR:  nxt_state = tms_lvl ? ST_E2I  : ST_PIR;
			ST_E2I:  nxt_state = tms_lvl ? ST_UIR  : ST_SHIR;
			ST_UIR:  nxt_state = tms_lvl ? ST_SDS  : ST_RTI;
			default: nxt_state = ST_TLR;
		endcase
	end

	// ==========================================================
	// TAP and debug control (test-reset domain)
	reg [`JPR_IR_W-1:0] ir_ff;
	reg [`JPR_IR_W-1:0] ir_sr_ff;
	reg [`JPR_DR_W-1:0] dr_sr_ff;
	reg                 break_pend_ff;
	reg                 restart_ff;
	reg                 halted_ff;

	wire [`JPR_DBG_W-1:0] dbg_status;
	assign dbg_status = {~sys_rst_lvl, break_pend_ff, halted_ff, `JPR_LOW};

	// Break is consumed when the core takes the halt
	wire halt_take;
	assign halt_take = sys_rst_lvl && !halted_ff && (break_pend_ff || dbg_req_lvl);

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff      <= ST_TLR;
			ir_ff         <= `JPR_IR_RST;
			ir_sr_ff      <= `JPR_IR_RST;
			dr_sr_ff      <= `JPR_DR_RST;
			break_pend_ff <= `JPR_LOW;
			restart_ff    <= `JPR_LOW;
		end else if (!trst_lvl) begin
			// Only TAP and debug logic; core state untouched here  // see [RULE_02] see [RULE_01]
			state_ff      <= ST_TLR;
			ir_ff         <= `JPR_IR_RST;
			ir_sr_ff      <= `JPR_IR_RST;
			dr_sr_ff      <= `JPR_DR_RST;
			break_pend_ff <= `JPR_LOW;
			restart_ff    <= `JPR_LOW;
		end else begin
			restart_ff <= `JPR_LOW;
			// A break written in this cycle is assigned later and wins
			if (halt_take)
				break_pend_ff <= `JPR_LOW;
			if (tck_rise) begin
				state_ff <= nxt_state; // see [RULE_13]
				case (state_ff)
					ST_TLR: begin
						ir_ff <= `JPR_IR_RST;
					end
					ST_CIR: begin
						ir_sr_ff <= `JPR_IR_CAPTURE;
					end
					ST_SHIR: begin
						ir_sr_ff <= {tdi_lvl, ir_sr_ff[`JPR_IR_W-1:1]}; // see [RULE_13]
					end
					ST_UIR: begin
						ir_ff <= ir_sr_ff;
					end
					ST_CDR: begin
						if (ir_ff == `JPR_INS_IDCODE)
							dr_sr_ff <= IDCODE_VAL;
						else if (ir_ff == `JPR_INS_DEBUG)
							dr_sr_ff <= {{(`JPR_DR_W-`JPR_DBG_W){1'b0}}, dbg_status};
						else
							dr_sr_ff <= `JPR_DR_RST;
					end
					ST_SHDR: begin
						if (ir_ff == `JPR_INS_IDCODE)
							dr_sr_ff <= {tdi_lvl, dr_sr_ff[`JPR_DR_W-1:1]};
						else if (ir_ff == `JPR_INS_DEBUG)
							dr_sr_ff[`JPR_DBG_MSB:0] <= {tdi_lvl, dr_sr_ff[`JPR_DBG_MSB:1]};
						else
							dr_sr_ff[0] <= tdi_lvl;
					end
					ST_UDR: begin
						if (ir_ff == `JPR_INS_DEBUG) begin
							// New request wins over a halt taken this cycle
							if (dr_sr_ff[`JPR_DBG_BREAK])
								break_pend_ff <= `JPR_HIGH;
							restart_ff <= dr_sr_ff[`JPR_DBG_RESTART];
						end
					end
					default: begin
						ir_ff <= ir_ff;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// TDO launch on falling test clock
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tdo_ff    <= `JPR_LOW;
			tdo_oe_ff <= `JPR_LOW;
		end else if (!trst_lvl) begin
			tdo_ff    <= `JPR_LOW;
			tdo_oe_ff <= `JPR_LOW;
		end else if (tck_fall) begin
			tdo_oe_ff <= (state_ff == ST_SHDR) || (state_ff == ST_SHIR); // see [RULE_13]
			tdo_ff    <= (state_ff == ST_SHIR) ? ir_sr_ff[0] : dr_sr_ff[0];
		end
	end

	// ==========================================================
	// Core control (system-reset domain)
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_reset_n_ff <= `JPR_LOW;
			halted_ff       <= `JPR_LOW;
			core_run_ff     <= `JPR_LOW;
		end else begin
			core_reset_n_ff <= sys_rst_lvl; // see [RULE_01]
			if (!sys_rst_lvl) begin
				// Core held; TAP and break request are left alone  // see [RULE_03]
				halted_ff   <= `JPR_LOW;
				core_run_ff <= `JPR_LOW;
			end else if (sys_rst_rise) begin
				// Decide before the first fetch  // see [RULE_05]
				halted_ff   <= break_pend_ff || dbg_req_lvl;
				core_run_ff <= !(break_pend_ff || dbg_req_lvl);
			end else if (halt_take) begin
				halted_ff   <= `JPR_HIGH;
				core_run_ff <= `JPR_LOW;
			end else if (halted_ff && restart_ff) begin
				halted_ff   <= `JPR_LOW;
				core_run_ff <= `JPR_HIGH;
			end
		end
	end

	// ==========================================================
	// Returned clock, acknowledge, debug reset
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			returned_test_clock_ff <= `JPR_LOW;
			debug_acknowledge_ff   <= `JPR_LOW;
			debug_logic_reset_n_ff <= `JPR_LOW;
		end else begin
			// Follows tck in the same cycle as the TAP acts on the edge
			returned_test_clock_ff <= tck_lvl; // see [RULE_08] see [RULE_09]
			debug_acknowledge_ff   <= halted_ff; // see [RULE_11]
			debug_logic_reset_n_ff <= trst_lvl; // see [RULE_02]
		end
	end

endmodule

// ### src/jpr_map.vh
// Purpose: Constants of the target-side debug port logic
// Assumes: Included by bare name from every design file
// Notes:   Definitions only
`ifndef JPR_MAP_VH
`define JPR_MAP_VH

// ==========================================================
// Instruction register
`define JPR_IR_W          4
`define JPR_IR_CAPTURE    4'h1
`define JPR_INS_IDCODE    4'h1
`define JPR_INS_DEBUG     4'h8
`define JPR_INS_BYPASS    4'hF

// ==========================================================
// Data registers
`define JPR_DR_W          32
`define JPR_DBG_W         4
`define JPR_DBG_MSB       3
`define JPR_DBG_BREAK     0
`define JPR_DBG_RESTART   1
`define JPR_DBG_HALTED    1
`define JPR_DBG_PEND      2
`define JPR_DBG_INRESET   3

// ==========================================================
// Reset values
`define JPR_LOW           1'b0
`define JPR_HIGH          1'b1
`define JPR_DR_RST        32'h0000_0000
`define JPR_IR_RST        4'h1

`endif

// ### src/jpr_pin_sync.v
// Purpose: Three-stage pin synchroniser with agreement filter and edge pulses
// Assumes: Pin is asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`include "jpr_map.vh"

module jpr_pin_sync #(
	parameter INIT = 1'b0
) (
	// Clock and reset
	input  wire clk,
	input  wire arst_n,
	// Pin and filtered result
	input  wire pin,
	output reg  level_ff,
	output reg  rise_ff,
	output reg  fall_ff
);

	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff    <= INIT;
			s2_ff    <= INIT;
			s3_ff    <= INIT;
			level_ff <= INIT;
			rise_ff  <= `JPR_LOW;
			fall_ff  <= `JPR_LOW;
		end else begin
			s1_ff   <= pin;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			rise_ff <= `JPR_LOW;
			fall_ff <= `JPR_LOW;
			// Change counts only when stages two and three agree
			if (s2_ff == s3_ff && s3_ff != level_ff) begin
				level_ff <= s3_ff;
				rise_ff  <= s3_ff;
				fall_ff  <= ~s3_ff;
			end
		end
	end

endmodule

// ### testbench/jpr_target_properties.sv
// Purpose: Port-level properties of the target debug port
// Assumes: Bound to every jpr_target instance
// Notes:   Windows of 8 cover the pin synchroniser depth
`timescale 1ns/10ps

// ========
// Checker
module jpr_target_properties (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Link pins
	input wire tck,
	input wire test_reset_n,
	input wire system_reset_n,
	input wire debug_request,
	input wire tdo_ff,
	input wire returned_test_clock_ff,
	input wire debug_acknowledge_ff,
	// Core side
	input wire core_reset_n_ff,
	input wire debug_logic_reset_n_ff,
	input wire core_run_ff
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Eight samples cover the three-stage pin filter plus the output flop
	sequence s_trst_low;
		(!test_reset_n)[*8];
	endsequence
	sequence s_sys_rst_low;
		(!system_reset_n)[*8];
	endsequence
	AST_TRST_ASSERT: assert property (s_trst_low |-> !debug_logic_reset_n_ff)
		else $error("debug logic not in reset");
	AST_SYS_RST_ASSERT: assert property (s_sys_rst_low |->
		!core_reset_n_ff && !core_run_ff && !debug_acknowledge_ff)
		else $error("core not in reset");
	AST_TRST_FREE: assert property (test_reset_n[*8] |-> debug_logic_reset_n_ff)
		else $error("debug logic reset without cause");
	AST_SYS_RST_FREE: assert property (system_reset_n[*8] |-> core_reset_n_ff)
		else $error("core reset without cause");
	AST_RET_CLK_HIGH: assert property (tck[*8] |-> returned_test_clock_ff)
		else $error("returned clock not high");
	AST_RET_CLK_LOW: assert property ((!tck)[*8] |-> !returned_test_clock_ff)
		else $error("returned clock not low");
	AST_REQ_HALT: assert property (debug_request[*8] |-> !core_run_ff)
		else $error("core runs under request");
	AST_TDO_FALL: assert property ($changed(tdo_ff) |-> !returned_test_clock_ff)
		else $error("tdo moved in high phase");
	AST_ACK_HALT: assert property ($rose(debug_acknowledge_ff) |->
		!$past(core_run_ff) && core_reset_n_ff)
		else $error("ack without halt");
endmodule

bind jpr_target jpr_target_properties u_props (
	.clk(clk), .arst_n(arst_n), .tck(tck), .test_reset_n(test_reset_n),
	.system_reset_n(system_reset_n), .debug_request(debug_request), .tdo_ff(tdo_ff),
	.returned_test_clock_ff(returned_test_clock_ff), .debug_acknowledge_ff(debug_acknowledge_ff),
	.core_reset_n_ff(core_reset_n_ff), .debug_logic_reset_n_ff(debug_logic_reset_n_ff),
	.core_run_ff(core_run_ff)
);

// ### testbench/jpr_probe_model.sv
// Purpose: Probe side of the debug link, adaptive clocking
// Assumes: Pins change at falling clk edges
// Notes:   Test clock parked low between scans
`timescale 1ns/10ps

// ========
// Probe
module jpr_probe_model #(
	parameter RET_WAIT_MAX = 40
) (
	// Clock
	input  wire clk,
	// Pins to the target
	output reg  tck,
	output reg  tms,
	output reg  tdi,
	output reg  test_reset_n,
	output reg  system_reset_n,
	output reg  debug_request,
	// Pins from the target
	input  wire tdo,
	input  wire returned_test_clock,
	// Status
	output reg  link_fail
);
	reg b;
	// Both resets held, separate lines
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		test_reset_n = 1'b0;
		system_reset_n = 1'b0;
		debug_request = 1'b0;
		link_fail = 1'b0;
	end
	// Bounded wait, a lost returned clock must not hang the link
	task half(input lvl);
		integer k;
		begin
			// Five clk here plus the returned-clock delay make a 160 ns period
			repeat (5) @(negedge clk);
			tck = lvl;
			k = 0;
			while (returned_test_clock !== lvl && k < RET_WAIT_MAX) begin
				@(negedge clk);
				k = k + 1;
			end
			if (k == RET_WAIT_MAX)
				link_fail = 1'b1;
		end
	endtask
	task bit_io(input t, input d, output o);
		begin
			tms = t;
			tdi = d;
			half(1'b1);
			o = tdo;
			half(1'b0);
		end
	endtask
	task tap_reset;
		begin
			repeat (5) bit_io(1'b1, 1'b0, b);
			bit_io(1'b0, 1'b0, b);
		end
	endtask
	task scan(input ir, input integer n, input [31:0] v, output [31:0] q);
		integer i;
		begin
			q = 32'h0000_0000;
			bit_io(1'b1, 1'b0, b);
			if (ir)
				bit_io(1'b1, 1'b0, b);
			bit_io(1'b0, 1'b0, b);
			bit_io(1'b0, 1'b0, b);
			for (i = 0; i < n; i = i + 1)
				bit_io(i == n - 1, v[i], q[i]);
			bit_io(1'b1, 1'b0, b);
			bit_io(1'b0, 1'b0, b);
		end
	endtask
	// Released lines rest at their pull levels; the clock keeps its level
	task hand_over(input integer n);
		begin
			tms = 1'b1;
			tdi = 1'b1;
			test_reset_n = 1'b1;
			repeat (n) @(negedge clk);
		end
	endtask
endmodule

// ### testbench/test_jtag_probe_reset_and_adaptive_clock.sv
// Purpose: Start-up, reset split and halt checks of the target debug port
// Assumes: Probe model drives every link pin
// Notes:   Waits of 10 clk cover the pin synchroniser
`timescale 1ns/10ps

// ========
// Bench
module test_jtag_probe_reset_and_adaptive_clock;
	localparam [31:0] ID_VAL = 32'h5a5a_0001; // Arbitrary value
	reg        clk;
	reg        arst_n;
	reg [31:0] o;
	integer    n_fail;
	integer    checked;
	wire       tck, tms, tdi, trst_n, sys_rst_n, dreq, link_fail;
	wire       tdo, tdo_oe, ret_clk, ack, core_rst_n, dbg_rst_n, run;
	// Pull-down holds the released data line
	wire       tdo_w = tdo_oe ? tdo : 1'b0;
	jpr_target #(.IDCODE_VAL(ID_VAL)) dut_u (.clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.test_reset_n(trst_n), .system_reset_n(sys_rst_n), .debug_request(dreq), .tdo_ff(tdo),
		.tdo_oe_ff(tdo_oe), .returned_test_clock_ff(ret_clk), .debug_acknowledge_ff(ack),
		.core_reset_n_ff(core_rst_n), .debug_logic_reset_n_ff(dbg_rst_n), .core_run_ff(run));
	jpr_probe_model probe_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(trst_n),
		.system_reset_n(sys_rst_n), .debug_request(dreq), .tdo(tdo_w), .returned_test_clock(ret_clk),
		.link_fail(link_fail));
	always #4 clk = ~clk;
	task chk(input ok, input [8*16-1:0] msg);
		begin
			checked = checked + 1;
			if (!ok) begin
				n_fail = n_fail + 1;
				$display("mismatch at %0t: %0s", $time, msg);
			end
		end
	endtask
	task wait_clk(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task wrap_up;
		begin
			if (n_fail == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task t_startup;
		begin
			wait_clk(10);
			chk(dbg_rst_n === 1'b0 && core_rst_n === 1'b0, "both resets");
			chk(ret_clk === 1'b0 && ack === 1'b0, "idle outputs");
			probe_u.test_reset_n = 1'b1;
			wait_clk(10);
			chk(dbg_rst_n === 1'b1 && core_rst_n === 1'b0, "trst only");
			probe_u.tap_reset;
			probe_u.scan(1'b1, 4, 32'h0000_0008, o);
			probe_u.scan(1'b0, 4, 32'h0000_0001, o);
			probe_u.system_reset_n = 1'b1;
			wait_clk(10);
			chk(core_rst_n === 1'b1 && run === 1'b0 && ack === 1'b1, "halt at start");
			probe_u.scan(1'b0, 4, 32'h0000_0000, o);
			chk(o[3:0] === 4'h2, "halted status");
		end
	endtask
	task t_trst;
		begin
			probe_u.test_reset_n = 1'b0;
			wait_clk(10);
			chk(dbg_rst_n === 1'b0 && ack === 1'b1 && core_rst_n === 1'b1, "trst scope");
			probe_u.test_reset_n = 1'b1;
			wait_clk(10);
			probe_u.tap_reset;
			probe_u.scan(1'b0, 32, 32'h0000_0000, o);
			chk(o === ID_VAL, "id after trst");
		end
	endtask
	task t_system_reset_n;
		begin
			probe_u.scan(1'b1, 4, 32'h0000_0008, o);
			probe_u.scan(1'b0, 4, 32'h0000_0002, o);
			wait_clk(4);
			chk(run === 1'b1 && ack === 1'b0, "restart");
			probe_u.system_reset_n = 1'b0;
			wait_clk(10);
			chk(run === 1'b0 && dbg_rst_n === 1'b1, "sys reset scope");
			probe_u.scan(1'b0, 4, 32'h0000_0000, o);
			chk(o[3:0] === 4'h8, "debug kept");
			probe_u.system_reset_n = 1'b1;
			wait_clk(10);
			chk(run === 1'b1, "run free");
			probe_u.debug_request = 1'b1;
			wait_clk(10);
			chk(run === 1'b0 && ack === 1'b1, "request halt");
			probe_u.debug_request = 1'b0;
			chk(link_fail === 1'b0, "link failure");
		end
	endtask
	// Core stays halted; a clean hand-over must leave TAP, IR and halt intact
	task t_handover;
		begin
			probe_u.hand_over(40);
			chk(dbg_rst_n === 1'b1 && ack === 1'b1 && tdo_oe === 1'b0, "hand-over kept");
			probe_u.scan(1'b0, 4, 32'h0000_0000, o);
			chk(o[3:0] === 4'h2, "TAP kept");
			chk(link_fail === 1'b0, "link failure");
		end
	endtask
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		n_fail = 0;
		checked = 0;
		wait_clk(4);
		arst_n = 1'b1;
		t_startup;
		t_trst;
		t_system_reset_n;
		t_handover;
		wrap_up;
	end
	// About five times the expected run
	initial begin
		#100000;
		n_fail = n_fail + 1;
		wrap_up;
	end
endmodule
